// ===== ipr_pkg.sv
// Purpose: Shared constants for the interrupt packet router
// Assumes: One 100 MHz clock; source lines arrive asynchronously
// Notes: Source table order is the offset order of the slot and on-board lines
package ipr_pkg;
	localparam int unsigned NUM_SLOT = 16;
	localparam int unsigned NUM_ONBOARD_IO_GROUP = 12;
	localparam int unsigned NUM_ERR = 3;
	localparam int unsigned NUM_GFX = 2;
	localparam int unsigned NUM_SRC = NUM_SLOT + NUM_ONBOARD_IO_GROUP + NUM_ERR + NUM_GFX;
	localparam int unsigned PAYLOAD_BYTES = 24;
	localparam logic [5:0] CODE_NONE = 6'h3F;
	localparam logic [6:0] OFS_NONE = 7'h7F;
	localparam logic [3:0] PRIO_NONE = 4'h0;
	localparam logic [5:0] CODE_ERR = 6'h3E;
	// Code, offset and priority per source; index 0 is slot 0 pin A
	localparam logic [5:0] SRC_CODE [NUM_SRC] = '{
		6'h06, 6'h04, 6'h03, 6'h01, 6'h0E, 6'h0C, 6'h0B, 6'h09,
		6'h16, 6'h14, 6'h13, 6'h11, 6'h1E, 6'h1C, 6'h1B, 6'h19,
		6'h20, 6'h21, 6'h22, 6'h24, 6'h1F, 6'h25, 6'h28, 6'h29,
		6'h2A, 6'h2B, 6'h2C, 6'h2D, CODE_ERR, CODE_ERR, CODE_ERR,
		6'h23, 6'h26};
	localparam logic [6:0] SRC_OFS [NUM_SRC] = '{
		7'h10, 7'h11, 7'h12, 7'h13, 7'h14, 7'h15, 7'h16, 7'h17,
		7'h18, 7'h19, 7'h1A, 7'h1B, 7'h1C, 7'h1D, 7'h1E, 7'h1F,
		7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27,
		7'h28, 7'h29, 7'h2A, 7'h2B, 7'h2E, 7'h2F, 7'h30,
		7'h23, 7'h26};
	localparam logic [3:0] SRC_PRIO [NUM_SRC] = '{
		4'h6, 4'h4, 4'h3, 4'h1, 4'h6, 4'h4, 4'h3, 4'h1,
		4'h6, 4'h4, 4'h3, 4'h1, 4'h6, 4'h4, 4'h3, 4'h1,
		4'h3, 4'h3, 4'h2, 4'h8, 4'h7, 4'h8, 4'h7, 4'h8,
		4'h2, 4'h4, 4'h4, 4'h7, 4'h8, 4'h8, 4'h8,
		4'h5, 4'h5};
	// Sources with pulse behaviour are the graphics inputs at the top
	localparam int unsigned FIRST_PULSE = NUM_SLOT + NUM_ONBOARD_IO_GROUP + NUM_ERR;
	typedef enum logic [2:0] {
		IPR_IDLE = 3'h1,
		IPR_SEND = 3'h2,
		IPR_WAIT = 3'h4
	} ipr_state_type;
endpackage

// ===== ipr_sel_if.sv
// Purpose: Carries the chosen source between arbiter and packet engine
// Assumes: Single clock domain
// Notes: Combinational selection result
`timescale 1ns/1ps
`default_nettype none
interface ipr_sel_if #(parameter int unsigned N = 33);
	logic [N-1:0] pend;
	logic found;
	logic [$clog2(N)-1:0] idx;
	modport arb (input pend, output found, output idx);
	modport eng (output pend, input found, input idx);
endinterface
`default_nettype wire

// ===== ipr_arbiter.sv
// Purpose: Picks the highest priority pending source
// Assumes: Priorities from the shared table
// Notes: Ties go to the lowest index, so slot lines win over on-board ones
`timescale 1ns/1ps
`default_nettype none
module ipr_arbiter #(
	parameter int unsigned N = ipr_pkg::NUM_SRC
) (
	ipr_sel_if.arb sel
);
	// The priority table has one entry per source and no more
	generate
		if (N != ipr_pkg::NUM_SRC) begin : g_bad_n
			$error("Source count must match the source tables");
		end
	endgenerate
	logic [3:0] best_prio;
	logic [$clog2(N)-1:0] best_idx;
	logic best_found;
	always_comb begin
		best_prio = ipr_pkg::PRIO_NONE;
		best_idx = '0;
		best_found = 1'b0;
		for (int i = N - 1; i >= 0; i--) begin
			if (sel.pend[i] && (!best_found ||
			    ipr_pkg::SRC_PRIO[i] >= best_prio)) begin
				best_prio = ipr_pkg::SRC_PRIO[i];
				best_idx = i[$clog2(N)-1:0];
				best_found = 1'b1;
			end
		end
	end
	assign sel.found = best_found;
	assign sel.idx = best_idx;
endmodule
`default_nettype wire

// ===== interrupt_packet_router.sv
// Overview of operation
// - Interrupts reach processor only as vectors.
// - Each interrupt is one 24-byte packet write.
// - Level interrupt lines become packets, never wires.
// - Interrupt number registered before reaching processor.
// - Slot pins at offsets 0x10-0x1F, priorities 6,4,3,1.
// - On-board, error, pulse and no-interrupt codes.
//
// Purpose: Turns interrupt lines into packet writes to the processor
// Assumes: Processor side accepts one 64-bit beat per pkt_ready cycle
// Notes: Packet is three 64-bit beats, first beat carries the vector
`timescale 1ns/1ps
`default_nettype none
module interrupt_packet_router #(
	parameter int unsigned BEAT_BYTES = 8
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [15:0] slot_pin_request,
	input wire logic [11:0] onboard_io_group_irq,
	input wire logic [2:0] internal_error_irq,
	input wire logic [1:0] display_pulse_irq,
	input wire logic [32:0] software_clear,
	output logic pkt_valid,
	input wire logic pkt_ready,
	output logic [63:0] pkt_data,
	output logic pkt_last,
	output logic [5:0] vector_number,
	output logic [32:0] pending_status
);
	localparam int unsigned N = ipr_pkg::NUM_SRC;
	localparam int unsigned BEATS = ipr_pkg::PAYLOAD_BYTES / BEAT_BYTES;
	localparam int unsigned IW = $clog2(N);

	// Beats are 64 bits wide and the two-bit counter holds four at most
	generate
		if (BEAT_BYTES != 8) begin : g_bad_beat
			$error("Beat width must be 8 bytes");
		end
		if (ipr_pkg::PAYLOAD_BYTES % BEAT_BYTES != 0) begin : g_bad_split
			$error("Beat width must divide the payload");
		end
		if (BEATS < 2 || BEATS > 4) begin : g_bad_count
			$error("Packet must hold two to four beats");
		end
	endgenerate

	// Two-stage synchronisers on every interrupt source line
	logic [N-1:0] raw;
	logic [N-1:0] sync1_q;
	logic [N-1:0] sync2_q;
	logic [N-1:0] prev_q;
	assign raw = {display_pulse_irq, internal_error_irq,
		onboard_io_group_irq, slot_pin_request};

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q <= '0;
		end else begin
			sync1_q <= raw;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	// Pulse sources catch a rising edge; level sources follow the line
	logic [N-1:0] is_pulse;
	logic [N-1:0] event_in;
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_src
			assign is_pulse[g] = (g >= ipr_pkg::FIRST_PULSE);
			assign event_in[g] = is_pulse[g] ?
				(sync2_q[g] & ~prev_q[g]) : sync2_q[g];
		end
	endgenerate

	// Per source state: pending, delivered (blocks re-send)
	logic [N-1:0] pend_q, pend_d;
	logic [N-1:0] done_q, done_d;
	logic [N-1:0] take_mask;
	logic [N-1:0] rearm;
	logic take;

	ipr_sel_if #(.N(N)) sel ();
	assign sel.pend = pend_q & ~done_q;
	ipr_arbiter #(.N(N)) u_arb (
		.sel(sel)
	);

	ipr_pkg::ipr_state_type state_q, state_d;
	logic [IW-1:0] cur_q;
	logic [1:0] beat_q;
	logic [5:0] vec_q;

	assign take = (state_q == ipr_pkg::IPR_IDLE) && sel.found;
	assign take_mask = take ? (N'(1) << sel.idx) : '0;
	// Re-arm needs the clear and a quiet line; pulse sources only the clear
	assign rearm = software_clear & (~sync2_q | is_pulse);
	// Set wins over clear: an edge that meets the clear starts a new round
	assign pend_d = (pend_q & ~(rearm & done_q)) |
		(event_in & (~done_q | rearm));
	assign done_d = (done_q & ~rearm) | take_mask;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pend_q <= '0;
			done_q <= '0;
		end else begin
			pend_q <= pend_d;
			done_q <= done_d;
		end
	end

	// Handshake and beat position
	logic beat_go;
	logic last_beat;
	logic next_is_last;
	logic leaving_send;
	assign beat_go = pkt_valid && pkt_ready;
	assign last_beat = (beat_q == 2'(BEATS - 1));
	assign next_is_last = (beat_q == 2'(BEATS - 2));
	assign leaving_send = beat_go && last_beat;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ipr_pkg::IPR_IDLE: begin
				if (sel.found)
					state_d = ipr_pkg::IPR_SEND;
			end
			ipr_pkg::IPR_SEND: begin
				if (leaving_send)
					state_d = ipr_pkg::IPR_WAIT;
			end
			// Three quiet cycles keep packets apart on the processor side; this state is one of them
			ipr_pkg::IPR_WAIT: begin
				state_d = ipr_pkg::IPR_IDLE;
			end
			default: state_d = ipr_pkg::IPR_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ipr_pkg::IPR_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// The winner is latched at take, so a later arrival of higher
	// priority cannot change the vector code of a packet already in flight
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cur_q <= '0;
			beat_q <= 2'h0;
		end else if (take) begin
			cur_q <= sel.idx;
			beat_q <= 2'h0;
		end else if (beat_go) begin
			beat_q <= beat_q + 2'h1;
		end
	end

	// Beat contents: vector code, offset, priority, then zero filler
	logic [5:0] cur_code;
	logic [6:0] cur_ofs;
	logic [3:0] cur_prio;
	logic cur_kind;
	logic head_beat;
	logic [63:0] beat_word;
	assign cur_code = ipr_pkg::SRC_CODE[cur_q];
	assign cur_ofs = ipr_pkg::SRC_OFS[cur_q];
	assign cur_prio = ipr_pkg::SRC_PRIO[cur_q];
	assign cur_kind = is_pulse[cur_q];
	assign head_beat = (beat_q == 2'h0);
	assign beat_word = head_beat ? {34'h0, cur_prio, 1'b0, cur_ofs,
		2'h0, cur_kind, 9'h0, cur_code} : 64'h0;

	// After an accepted beat the next one goes out as zero data; that
	// is only right because every beat but the first is filler
	logic in_send;
	logic valid_d;
	logic [63:0] data_d;
	logic last_d;
	assign in_send = (state_q == ipr_pkg::IPR_SEND) && !leaving_send;
	assign valid_d = in_send;
	assign data_d = (in_send && !beat_go) ? beat_word : 64'h0;
	assign last_d = in_send && (beat_go ? next_is_last : last_beat);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pkt_valid <= 1'b0;
			pkt_data <= 64'h0;
			pkt_last <= 1'b0;
		end else begin
			pkt_valid <= valid_d;
			pkt_data <= data_d;
			pkt_last <= last_d;
		end
	end

	// Winner code goes through two stages; the second one is what the
	// processor side reads, so it never sees the arbiter settle
	logic [5:0] vec_d;
	assign vec_d = sel.found ? ipr_pkg::SRC_CODE[sel.idx] :
		ipr_pkg::CODE_NONE;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			vec_q <= ipr_pkg::CODE_NONE;
			vector_number <= ipr_pkg::CODE_NONE;
		end else begin
			vec_q <= vec_d;
			vector_number <= vec_q;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pending_status <= '0;
		end else begin
			pending_status <= pend_q;
		end
	end
endmodule
`default_nettype wire

// ===== ipr_sva.sv
// Purpose: Port checks for the interrupt packet router
// Assumes: One clock, rst_b active low
// Notes: Beat 0 is recognised by its offset field
`timescale 1ns/1ps
`default_nettype none
module ipr_sva (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [32:0] software_clear,
	input wire logic pkt_valid,
	input wire logic pkt_ready,
	input wire logic [63:0] pkt_data,
	input wire logic pkt_last,
	input wire logic [5:0] vector_number,
	input wire logic [32:0] pending_status
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_hold; pkt_valid && !pkt_ready |=> pkt_valid; endproperty
	a_hold: assert property (p_hold) else $error("beat dropped");
	property p_last; pkt_last && !pkt_ready |=> pkt_last; endproperty
	a_last: assert property (p_last) else $error("last lost");
	property p_gap; pkt_valid && pkt_ready && pkt_last |=> !pkt_valid;
	endproperty
	a_gap: assert property (p_gap) else $error("no idle gap");
	property p_first; $rose(pkt_valid) |-> pkt_data[5:0] != 6'h3F; endproperty
	a_first: assert property (p_first) else $error("empty vector");
	property p_slot; pkt_valid && pkt_data[24:18] == 7'h10
		|-> pkt_data[5:0] == 6'h06 && pkt_data[29:26] == 4'h6; endproperty
	a_slot: assert property (p_slot) else $error("slot0 A fields");
	property p_err; pkt_valid && pkt_data[24:18] == 7'h30
		|-> pkt_data[29:26] == 4'h8; endproperty
	a_err: assert property (p_err) else $error("bus error prio");
	property p_none; pending_status == 33'h0 [*3] |-> vector_number == 6'h3F;
	endproperty
	a_none: assert property (p_none) else $error("idle code");
	property p_vec; vector_number != 6'h3F
		|-> $past(pending_status) != 33'h0; endproperty
	a_vec: assert property (p_vec) else $error("vector early");
	property p_clear; $fell(pending_status[0]) |-> $past(software_clear[0])
		|| $past(software_clear[0], 2); endproperty
	a_clear: assert property (p_clear) else $error("uncleared drop");
endmodule
bind interrupt_packet_router ipr_sva i_ipr_sva (.clk, .rst_b,
	.software_clear, .pkt_valid, .pkt_ready, .pkt_data, .pkt_last,
	.vector_number, .pending_status);
`default_nettype wire

// ===== ipr_proc_model.sv
// Purpose: Processor side that takes packet beats
// Assumes: Beat taken when valid and ready meet at an edge
// Notes: Slow mode stalls every other cycle
`timescale 1ns/1ps
`default_nettype none
module ipr_proc_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic slow,
	input wire logic pkt_valid,
	input wire logic [63:0] pkt_data,
	input wire logic pkt_last,
	output logic pkt_ready,
	output logic [63:0] first_beat,
	output int n_pkt,
	output int last_len
);
	int beat;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pkt_ready <= 1'b0;
			beat <= 0;
			n_pkt <= 0;
			last_len <= 0;
			first_beat <= 64'h0;
		end else begin
			pkt_ready <= slow ? ~pkt_ready : 1'b1;
			if (pkt_valid && pkt_ready) begin
				if (beat == 0)
					first_beat <= pkt_data;
				beat <= pkt_last ? 0 : beat + 1;
				if (pkt_last) begin
					n_pkt <= n_pkt + 1;
					last_len <= beat + 1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ===== interrupt_packet_router_tb.sv
// Purpose: Bench for the interrupt packet router
// Assumes: src and clr are ordered like software_clear
// Notes: Each source is raised, checked, then released and cleared
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin n_compared++; if ((g) !== (e)) begin \
	n_mismatch++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module interrupt_packet_router_tb;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic slow = 1'b0;
	logic [32:0] src = 33'h0;
	logic [32:0] clr = 33'h0;
	logic pkt_valid, pkt_ready, pkt_last;
	logic [63:0] pkt_data, fb;
	logic [5:0] vector_number;
	logic [32:0] pending_status;
	int n_pkt, last_len, n_mismatch, n_compared, cyc;
	always #5 clk = ~clk;
	interrupt_packet_router i_interrupt_packet_router (.clk, .rst_b,
		.slot_pin_request(src[15:0]), .onboard_io_group_irq(src[27:16]),
		.internal_error_irq(src[30:28]), .display_pulse_irq(src[32:31]),
		.software_clear(clr), .pkt_valid, .pkt_ready, .pkt_data,
		.pkt_last, .vector_number, .pending_status);
	ipr_proc_model i_ipr_proc_model (.clk, .rst_b, .slow, .pkt_valid,
		.pkt_data, .pkt_last, .pkt_ready, .first_beat(fb), .n_pkt, .last_len);
	task automatic wait_pkt(input int n);
		for (int t = 0; t < 80 && n_pkt < n; t++)
			@(posedge clk);
		`CHK("packets", n, n_pkt)
	endtask
	task automatic release_all;
		src <= 33'h0;
		repeat (3) @(posedge clk);
		clr <= 33'h1FFFFFFFF;
		repeat (2) @(posedge clk);
		clr <= 33'h0;
		repeat (2) @(posedge clk);
		`CHK("pending", 33'h0, pending_status)
	endtask
	task automatic hit(input int i, input logic [5:0] c, input logic [6:0] o,
		input logic [3:0] p);
		int k0;
		k0 = n_pkt;
		src[i] <= 1'b1;
		// Pulse inputs drop at once; level ones hold to test no resend
		if (i > 30) begin
			@(posedge clk);
			src[i] <= 1'b0;
		end
		wait_pkt(k0 + 1);
		`CHK("code", c, fb[5:0])
		`CHK("offset", o, fb[24:18])
		`CHK("prio", p, fb[29:26])
		`CHK("pulse", i > 30, fb[15])
		`CHK("beats", 3, last_len)
		repeat (20) @(posedge clk);
		`CHK("resend", k0 + 1, n_pkt)
		release_all();
	endtask
	task automatic test_slots;
		for (int i = 0; i < 16; i++) begin
			slow <= i[0];
			hit(i, i == 0 ? 6'h06 : ipr_pkg::SRC_CODE[i], 7'h10 + i[6:0],
				i % 4 == 0 ? 4'h6 : i % 4 == 1 ? 4'h4 : i % 4 == 2 ? 4'h3 : 4'h1);
		end
		$display("test slots done");
	endtask
	task automatic test_onboard;
		for (int i = 0; i < 12; i++)
			hit(16 + i, ipr_pkg::SRC_CODE[16 + i], 7'h20 + i[6:0],
				ipr_pkg::SRC_PRIO[16 + i]);
		for (int i = 0; i < 3; i++)
			hit(28 + i, ipr_pkg::CODE_ERR, 7'h2E + i[6:0], 4'h8);
		hit(31, 6'h23, ipr_pkg::SRC_OFS[31], 4'h5);
		hit(32, 6'h26, ipr_pkg::SRC_OFS[32], 4'h5);
		$display("test onboard done");
	endtask
	task automatic test_prio;
		int k0;
		k0 = n_pkt;
		`CHK("idle", 6'h3F, vector_number)
		src[3] <= 1'b1;
		src[0] <= 1'b1;
		wait_pkt(k0 + 2);
		`CHK("order", 6'h01, fb[5:0])
		release_all();
		$display("test prio done");
	endtask
	task automatic test_rearm;
		int k0;
		k0 = n_pkt;
		src[20] <= 1'b1;
		wait_pkt(k0 + 1);
		// A clear while the line is still high must be refused
		clr[20] <= 1'b1;
		repeat (2) @(posedge clk);
		clr[20] <= 1'b0;
		repeat (20) @(posedge clk);
		`CHK("clear high", k0 + 1, n_pkt)
		`CHK("still pending", 1'b1, pending_status[20])
		release_all();
		src[20] <= 1'b1;
		wait_pkt(k0 + 2);
		`CHK("rearmed", 6'h1F, fb[5:0])
		release_all();
		src[31] <= 1'b1;
		@(posedge clk);
		src[31] <= 1'b0;
		wait_pkt(k0 + 3);
		// Second edge lands in the cycle of the clear of the first
		src[31] <= 1'b1;
		@(posedge clk);
		src[31] <= 1'b0;
		@(posedge clk);
		clr[31] <= 1'b1;
		@(posedge clk);
		clr[31] <= 1'b0;
		wait_pkt(k0 + 4);
		release_all();
		$display("test rearm done");
	endtask
	task test_done;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			test_done();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk);
		test_prio();
		test_rearm();
		test_slots();
		test_onboard();
		test_done();
	end
endmodule
`default_nettype wire
